// [hdl/pte_event_ctrl.sv]
// Timestamper, event generator and insertion control register bank
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// [RQ1] Clock output divides base clock; zero disables
// [RQ2] Stamper three edge select, ignored for packets
// [RQ3] Stamper three source: ingress start or pins
// [RQ4] Stamper two edge select, ignored for packets
// [RQ5] Stamper two source: egress start or pins
// [RQ6] Stamper one edge select always applies
// [RQ7] Stamper one source through both dividers
// [RQ8] Second divider code table, eight factors; the table gives 1000 for both codes 2 and 3, so only seven differ
// [RQ9] First divider; zero and one bypass
// [RQ10] Reset bit rising edge resets generator
// [RQ11] Hold bit pauses generator command processing
// [RQ12] Resolution bit: 1 ns or 1/256 ns
// [RQ13] Per-type admission into egress, ingress FIFOs
// [RQ14] Admission only when source is packet start
// [RQ15] One-step egress enable for types zero-three
// [RQ16] Residence correction enable, peer-delay extension
// [RQ17] One-step overrides residence correction per type
// [RQ18] Clear designated bytes in egress messages
// [RQ19] Circuit-emulation insertion only in that mode
// [RQ20] Ingress timestamp write enable per type
// [RQ21] Seconds insertion width: 0,1,4,6 bytes
// [RQ22] Seconds byte offset from header start
// [RQ23] Pin captures flag edge polarity, rising one
// [RQ24] Reserved bits read zero, writes ignored
module pte_event_ctrl
   import pte_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [pte_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [pte_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [pte_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic [2:0] gpio_i,
   input wire logic gen_one_feedback_i,
   input wire logic egress_sop_i,
   input wire logic ingress_sop_i,
   input wire logic circuit_mode_i,
   input wire logic egress_msg_valid_i,
   input wire logic [pte_pkg::TYPE_W-1:0] egress_msg_type_i,
   input wire logic ingress_msg_valid_i,
   input wire logic [pte_pkg::TYPE_W-1:0] ingress_msg_type_i,
   output logic time_clock_output_pin_o,
   output logic [pte_pkg::NUM_STAMP-1:0] stamp_capture_o,
   output logic [pte_pkg::NUM_STAMP-1:0] stamp_edge_o,
   output logic [1:0] gen_reset_o,
   output logic [1:0] gen_hold_o,
   output logic [1:0] gen_resolution_o,
   output logic egress_fifo_write_o,
   output logic ingress_fifo_write_o,
   output logic egress_one_step_o,
   output logic egress_residence_o,
   output logic ingress_insert_o,
   output logic circuit_insert_o,
   output logic clear_insert_bytes_o,
   output logic [1:0] seconds_insert_width_o,
   output logic [5:0] seconds_insert_offset_o
);
   import pte_pkg::*;

   typedef struct packed {
      logic [15:0] clk_ctrl;
      logic [15:0] src_edge;
      logic [15:0] gen_ctrl;
      logic [15:0] div_one;
      logic [15:0] fifo_en;
      logic [15:0] ins_en;
      logic [15:0] ins_ctrl;
      logic [15:0] rdata;
      logic raw1_prev;
      logic d1_prev;
      logic [15:0] div1_cnt;
      logic div1_lvl;
      logic [12:0] div2_cnt;
      logic div2_lvl;
      logic [2:0] src_prev;
      logic [2:0] cap;
      logic [2:0] pol;
      logic [1:0] gen_rst;
      logic egr_fifo;
      logic ing_fifo;
      logic one_step;
      logic residence;
      logic ing_insert;
      logic circ_insert;
   } pte_state_t;

   pte_state_t s;
   pte_state_t next_s;

   always_comb begin
      logic [1:0] sel;
      logic [1:0] edge_sel;
      logic [1:0] sel1;
      logic raw1;
      logic d1;
      logic d2;
      logic lvl;
      logic rise;
      logic fall;
      logic [16:0] inc1;
      logic [13:0] inc2;
      logic [12:0] f2;
      logic [7:0] egr_en;
      logic [7:0] ing_en;
      logic [7:0] ins_types;
      logic [3:0] step_types;
      logic step_hit;
      logic [2:0] et;
      logic [2:0] it;
      sel = SRC_INTERNAL;
      edge_sel = EDGE_NONE;
      sel1 = s.src_edge[STAMP_SRC_LSB +: 2];
      raw1 = 1'b0;
      d1 = 1'b0;
      d2 = 1'b0;
      lvl = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      inc1 = '0;
      inc2 = '0;
      f2 = div_two_factor(s.src_edge[DIV_TWO_LSB +: 3]);
      egr_en = s.fifo_en[EGR_FIFO_LSB +: 8];
      ing_en = s.fifo_en[ING_FIFO_LSB +: 8];
      ins_types = s.ins_en[ING_INS_LSB +: 8];
      step_types = s.ins_en[ONE_STEP_LSB +: 4];
      et = egress_msg_type_i[2:0];
      it = ingress_msg_type_i[2:0];
      step_hit = 1'b0;
      next_s = s;

      // Register writes; masks keep reserved bits at zero
      if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_CLOCK_OUT: next_s.clk_ctrl = reg_wdata_i & MASK_CLOCK_OUT; // see [RQ1] see [RQ24]
            ADDR_SRC_EDGE: next_s.src_edge = reg_wdata_i & MASK_SRC_EDGE; // see [RQ24]
            ADDR_GEN_CTRL: next_s.gen_ctrl = reg_wdata_i & MASK_GEN_CTRL; // see [RQ24]
            ADDR_DIV_ONE: next_s.div_one = reg_wdata_i & MASK_DIV_ONE;
            ADDR_FIFO_EN: next_s.fifo_en = reg_wdata_i & MASK_FIFO_EN;
            ADDR_INS_EN: next_s.ins_en = reg_wdata_i & MASK_INS_EN;
            ADDR_INS_CTRL: next_s.ins_ctrl = reg_wdata_i & MASK_INS_CTRL; // see [RQ24]
            default: ;
         endcase
      end

      // Registered read data; unmapped offsets read zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_CLOCK_OUT: next_s.rdata = s.clk_ctrl;
            ADDR_SRC_EDGE: next_s.rdata = s.src_edge;
            ADDR_GEN_CTRL: next_s.rdata = s.gen_ctrl;
            ADDR_DIV_ONE: next_s.rdata = s.div_one;
            ADDR_FIFO_EN: next_s.rdata = s.fifo_en;
            ADDR_INS_EN: next_s.rdata = s.ins_en;
            ADDR_INS_CTRL: next_s.rdata = s.ins_ctrl;
            default: next_s.rdata = 16'h0000; // see [RQ24]
         endcase
      end

      // Generator reset on a low-to-high change of the stored bit
      next_s.gen_rst[1] = next_s.gen_ctrl[G2_RST_BIT] & ~s.gen_ctrl[G2_RST_BIT]; // see [RQ10]
      next_s.gen_rst[0] = next_s.gen_ctrl[G1_RST_BIT] & ~s.gen_ctrl[G1_RST_BIT]; // see [RQ10]

      // Stamper one source and first divider
      raw1 = (sel1 == SRC_INTERNAL) ? gen_one_feedback_i : gpio_i[sel1 - 2'b01]; // see [RQ7]
      next_s.raw1_prev = raw1;
      if (raw1 && !s.raw1_prev) begin
         inc1 = {1'b0, s.div1_cnt} + 17'h00001;
         next_s.div1_cnt = (inc1 >= {1'b0, s.div_one}) ? 16'h0000 : inc1[15:0]; // see [RQ9]
         next_s.div1_lvl = next_s.div1_cnt < (s.div_one >> 1);
      end
      d1 = (s.div_one <= 16'h0001) ? raw1 : s.div1_lvl; // see [RQ9]

      // Second divider after the first
      next_s.d1_prev = d1;
      if (d1 && !s.d1_prev) begin
         inc2 = {1'b0, s.div2_cnt} + 14'h0001;
         next_s.div2_cnt = (inc2 >= {1'b0, f2}) ? 13'h0000 : inc2[12:0]; // see [RQ8]
         next_s.div2_lvl = next_s.div2_cnt < (f2 >> 1);
      end
      d2 = (f2 == DIV2_F000) ? d1 : s.div2_lvl; // see [RQ7] see [RQ8]

      // Edge selection per stamper
      for (int i = 0; i < NUM_STAMP; i++) begin
         sel = s.src_edge[STAMP_SRC_LSB + STAMP_STRIDE * i +: 2];
         edge_sel = s.src_edge[STAMP_EDGE_LSB + STAMP_STRIDE * i +: 2];
         if (i == 0) begin
            lvl = d2;
         end else begin
            lvl = (sel == SRC_INTERNAL) ? 1'b0 : gpio_i[sel - 2'b01]; // see [RQ3] see [RQ5]
         end
         rise = lvl & ~s.src_prev[i];
         fall = ~lvl & s.src_prev[i];
         next_s.src_prev[i] = lvl;
         if (i != 0 && sel == SRC_INTERNAL) begin
            // Packet start feeds the stamper, edge field unused
            next_s.cap[i] = (i == 1) ? egress_sop_i : ingress_sop_i; // see [RQ2] see [RQ3] see [RQ4] see [RQ5]
            next_s.pol[i] = 1'b0;
         end else begin
            next_s.cap[i] = (edge_sel[0] & rise) | (edge_sel[1] & fall); // see [RQ2] see [RQ4] see [RQ6]
            next_s.pol[i] = rise; // see [RQ23]
         end
      end

      // Message-type gating into the stamp FIFOs
      next_s.egr_fifo = egress_msg_valid_i & ~egress_msg_type_i[3] & egr_en[et]
         & (s.src_edge[STAMP_SRC_LSB + STAMP_STRIDE +: 2] == SRC_INTERNAL); // see [RQ13] see [RQ14]
      next_s.ing_fifo = ingress_msg_valid_i & ~ingress_msg_type_i[3] & ing_en[it]
         & (s.src_edge[STAMP_SRC_LSB + 2 * STAMP_STRIDE +: 2] == SRC_INTERNAL); // see [RQ13] see [RQ14]

      // One-step and residence correction per egress message
      step_hit = (egress_msg_type_i[3:2] == 2'b00) & step_types[et[1:0]]; // see [RQ15]
      next_s.one_step = egress_msg_valid_i & step_hit;
      if (egress_msg_type_i[3:1] == 3'b001) begin
         next_s.residence = egress_msg_valid_i & ~step_hit & s.ins_en[TC_BIT] & s.ins_en[PD_BIT]; // see [RQ16] see [RQ17]
      end else begin
         next_s.residence = egress_msg_valid_i & ~step_hit & s.ins_en[TC_BIT]; // see [RQ16] see [RQ17]
      end

      // Ingress insertion
      next_s.ing_insert = ingress_msg_valid_i & ~ingress_msg_type_i[3] & ins_types[it]; // see [RQ20]
      next_s.circ_insert = s.ins_en[TOP_BIT] & circuit_mode_i; // see [RQ19]
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
         s.clk_ctrl <= RST_CLOCK_OUT;
         s.src_edge <= RST_SRC_EDGE;
         s.gen_ctrl <= RST_GEN_CTRL;
         s.div_one <= RST_DIV_ONE;
         s.fifo_en <= RST_FIFO_EN;
         s.ins_en <= RST_INS_EN;
         s.ins_ctrl <= RST_INS_CTRL;
      end else begin
         s <= next_s;
      end
   end

   pte_clock_out u_clock_out (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .clock_out_divider_i(s.clk_ctrl[CLK_DIV_LSB +: 8]), // see [RQ1]
      .clock_out_invert_i(s.clk_ctrl[CLK_INV_BIT]), // see [RQ1]
      .time_clock_output_pin_o(time_clock_output_pin_o)
   );

   assign reg_rdata_o = s.rdata;
   assign stamp_capture_o = s.cap;
   assign stamp_edge_o = s.pol;
   assign gen_reset_o = s.gen_rst;
   assign gen_hold_o = {s.gen_ctrl[G2_HOLD_BIT], s.gen_ctrl[G1_HOLD_BIT]}; // see [RQ11]
   assign gen_resolution_o = {s.gen_ctrl[G2_RES_BIT], s.gen_ctrl[G1_RES_BIT]}; // see [RQ12]
   assign egress_fifo_write_o = s.egr_fifo;
   assign ingress_fifo_write_o = s.ing_fifo;
   assign egress_one_step_o = s.one_step;
   assign egress_residence_o = s.residence;
   assign ingress_insert_o = s.ing_insert;
   assign circuit_insert_o = s.circ_insert;
   assign clear_insert_bytes_o = s.ins_en[CLR_BIT]; // see [RQ18]
   assign seconds_insert_width_o = s.ins_ctrl[SEC_W_LSB +: 2]; // see [RQ21]
   assign seconds_insert_offset_o = s.ins_ctrl[SECONDS_INSERT_OFFSET_LSB +: 6]; // see [RQ22]
endmodule : pte_event_ctrl
`default_nettype wire

// [hdl/pte_pkg.sv]
// Constants for the precision-time event control register bank
package pte_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int TYPE_W = 4;
   localparam int NUM_STAMP = 3;

   // Register offsets
   localparam logic [7:0] ADDR_CLOCK_OUT = 8'h11;
   localparam logic [7:0] ADDR_SRC_EDGE = 8'h12;
   localparam logic [7:0] ADDR_GEN_CTRL = 8'h13;
   localparam logic [7:0] ADDR_DIV_ONE = 8'h14;
   localparam logic [7:0] ADDR_FIFO_EN = 8'h15;
   localparam logic [7:0] ADDR_INS_EN = 8'h16;
   localparam logic [7:0] ADDR_INS_CTRL = 8'h17;

   // Writable bits; all others read zero
   localparam logic [15:0] MASK_CLOCK_OUT = 16'h01FF;
   localparam logic [15:0] MASK_SRC_EDGE = 16'hFFF7;
   localparam logic [15:0] MASK_GEN_CTRL = 16'h0077;
   localparam logic [15:0] MASK_DIV_ONE = 16'hFFFF;
   localparam logic [15:0] MASK_FIFO_EN = 16'hFFFF;
   localparam logic [15:0] MASK_INS_EN = 16'hFFFF;
   localparam logic [15:0] MASK_INS_CTRL = 16'hFF00;

   // Reset values
   localparam logic [15:0] RST_CLOCK_OUT = 16'h0000;
   localparam logic [15:0] RST_SRC_EDGE = 16'h0000;
   localparam logic [15:0] RST_GEN_CTRL = 16'h0000;
   localparam logic [15:0] RST_DIV_ONE = 16'h0000;
   localparam logic [15:0] RST_FIFO_EN = 16'h0000;
   localparam logic [15:0] RST_INS_EN = 16'h0000;
   localparam logic [15:0] RST_INS_CTRL = 16'h0000;

   // Field positions
   localparam int CLK_INV_BIT = 8;
   localparam int CLK_DIV_LSB = 0;
   localparam int STAMP_SRC_LSB = 4;
   localparam int STAMP_EDGE_LSB = 6;
   localparam int STAMP_STRIDE = 4;
   localparam int DIV_TWO_LSB = 0;
   localparam int G2_RST_BIT = 6;
   localparam int G2_HOLD_BIT = 5;
   localparam int G2_RES_BIT = 4;
   localparam int G1_RST_BIT = 2;
   localparam int G1_HOLD_BIT = 1;
   localparam int G1_RES_BIT = 0;
   localparam int EGR_FIFO_LSB = 8;
   localparam int ING_FIFO_LSB = 0;
   localparam int PD_BIT = 15;
   localparam int CLR_BIT = 14;
   localparam int TOP_BIT = 13;
   localparam int TC_BIT = 12;
   localparam int ONE_STEP_LSB = 8;
   localparam int ING_INS_LSB = 0;
   localparam int SEC_W_LSB = 14;
   localparam int SECONDS_INSERT_OFFSET_LSB = 8;

   // Source and edge codes
   localparam logic [1:0] SRC_INTERNAL = 2'b00;
   localparam logic [1:0] EDGE_NONE = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_FALL = 2'b10;
   localparam logic [1:0] EDGE_BOTH = 2'b11;

   // Second divider factors
   localparam logic [12:0] DIV2_F000 = 13'h0001;
   localparam logic [12:0] DIV2_F001 = 13'h000A;
   localparam logic [12:0] DIV2_F010 = 13'h03E8;
   localparam logic [12:0] DIV2_F011 = 13'h03E8;
   localparam logic [12:0] DIV2_F100 = 13'h0002;
   localparam logic [12:0] DIV2_F101 = 13'h0050;
   localparam logic [12:0] DIV2_F110 = 13'h0320;
   localparam logic [12:0] DIV2_F111 = 13'h1F40;

   function automatic logic [12:0] div_two_factor(input logic [2:0] code);
      logic [12:0] f;
      f = DIV2_F000;
      case (code)
         3'h0: f = DIV2_F000;
         3'h1: f = DIV2_F001;
         3'h2: f = DIV2_F010;
         3'h3: f = DIV2_F011;
         3'h4: f = DIV2_F100;
         3'h5: f = DIV2_F101;
         3'h6: f = DIV2_F110;
         3'h7: f = DIV2_F111;
         default: f = DIV2_F000;
      endcase
      return f;
   endfunction : div_two_factor
endpackage : pte_pkg

// [hdl/pte_clock_out.sv]
// Divided time clock output generator
`timescale 1ns/1ns
`default_nettype none
module pte_clock_out
   import pte_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] clock_out_divider_i,
   input wire logic clock_out_invert_i,
   output logic time_clock_output_pin_o
);
   typedef struct packed {
      logic [7:0] cnt;
      logic pin;
   } pte_clk_state_t;

   pte_clk_state_t s;
   pte_clk_state_t next_s;

   always_comb begin
      logic [8:0] inc;
      logic [8:0] half;
      inc = {1'b0, s.cnt} + 9'h001;
      half = ({1'b0, clock_out_divider_i} + 9'h001) >> 1;
      next_s = s;
      if (clock_out_divider_i == 8'h00) begin
         // Divider zero stops the output low
         next_s.cnt = 8'h00;
         next_s.pin = 1'b0;
      end else begin
         next_s.cnt = (inc >= {1'b0, clock_out_divider_i}) ? 8'h00 : inc[7:0];
         next_s.pin = (next_s.cnt < half[7:0]) ^ clock_out_invert_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign time_clock_output_pin_o = s.pin;
endmodule : pte_clock_out
`default_nettype wire

// [tb/pte_event_ctrl_monitor.sv]
// Assertion checker for the event control register bank
`timescale 1ns/1ns
`default_nettype none
module pte_event_ctrl_monitor
   import pte_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [pte_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [pte_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [pte_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic circuit_mode_i,
   input wire logic egress_msg_valid_i,
   input wire logic [pte_pkg::TYPE_W-1:0] egress_msg_type_i,
   input wire logic [1:0] gen_reset_o,
   input wire logic [1:0] gen_hold_o,
   input wire logic egress_fifo_write_o,
   input wire logic egress_one_step_o,
   input wire logic egress_residence_o,
   input wire logic circuit_insert_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   gen_one_rst_a: assert property (gen_reset_o[0] |-> $past(reg_wr_i && reg_addr_i == 8'h13 && reg_wdata_i[2]))
      else $error("generator one reset without write");
   gen_two_rst_a: assert property (gen_reset_o[1] |-> $past(reg_wr_i && reg_addr_i == 8'h13 && reg_wdata_i[6]))
      else $error("generator two reset without write");
   gen_hold_a: assert property (reg_wr_i && reg_addr_i == 8'h13 |=>
      gen_hold_o == {$past(reg_wdata_i[5]), $past(reg_wdata_i[1])}) else $error("hold level wrong");
   egr_fifo_a: assert property (egress_fifo_write_o |-> $past(egress_msg_valid_i && egress_msg_type_i < 4'h8))
      else $error("egress fifo write without message");
   one_step_type_a: assert property (egress_one_step_o |-> $past(egress_msg_valid_i && egress_msg_type_i < 4'h4))
      else $error("one-step for wrong type");
   step_over_tc_a: assert property (egress_one_step_o |-> !egress_residence_o)
      else $error("residence with one-step");
   unmapped_read_a: assert property (reg_rd_i && !(reg_addr_i inside {[8'h11:8'h17]}) |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   circuit_ins_a: assert property (circuit_insert_o |-> $past(circuit_mode_i))
      else $error("circuit insert outside mode");
endmodule : pte_event_ctrl_monitor
bind pte_event_ctrl pte_event_ctrl_monitor mon (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .circuit_mode_i(circuit_mode_i), .egress_msg_valid_i(egress_msg_valid_i), .egress_msg_type_i(egress_msg_type_i),
   .gen_reset_o(gen_reset_o), .gen_hold_o(gen_hold_o), .egress_fifo_write_o(egress_fifo_write_o),
   .egress_one_step_o(egress_one_step_o), .egress_residence_o(egress_residence_o),
   .circuit_insert_o(circuit_insert_o));
`default_nettype wire

// [tb/pte_event_ctrl_test.sv]
// Self-checking bench for the event control register bank
`timescale 1ns/1ns
`default_nettype none
module pte_event_ctrl_test;
   import pte_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, fb = 0, es = 0, is = 0, cm = 0, ev = 0, iv = 0;
   logic [7:0] a = 0;
   logic [15:0] wd = 0, rdat;
   logic [3:0] et = 0, it = 0;
   logic [2:0] gp = 0, cap, edg;
   logic cko, efw, ifw, ost, res, iins, cins, clr;
   logic [1:0] grst, ghold, gres, sw;
   logic [5:0] so;
   int fails = 0, n_compared = 0;
   always #5 clk = ~clk;
   pte_event_ctrl dut (.sys_clk_i(clk), .resetn_i(rst_n), .reg_addr_i(a), .reg_wr_i(wr), .reg_wdata_i(wd),
      .reg_rd_i(rd), .reg_rdata_o(rdat), .gpio_i(gp), .gen_one_feedback_i(fb), .egress_sop_i(es),
      .ingress_sop_i(is), .circuit_mode_i(cm), .egress_msg_valid_i(ev), .egress_msg_type_i(et),
      .ingress_msg_valid_i(iv), .ingress_msg_type_i(it), .time_clock_output_pin_o(cko),
      .stamp_capture_o(cap), .stamp_edge_o(edg), .gen_reset_o(grst), .gen_hold_o(ghold),
      .gen_resolution_o(gres), .egress_fifo_write_o(efw), .ingress_fifo_write_o(ifw),
      .egress_one_step_o(ost), .egress_residence_o(res), .ingress_insert_o(iins),
      .circuit_insert_o(cins), .clear_insert_bytes_o(clr), .seconds_insert_width_o(sw),
      .seconds_insert_offset_o(so));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic w(input logic [7:0] ad, input logic [15:0] d);
      @(posedge clk);
      a <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : w
   task automatic r(input logic [7:0] ad, output logic [15:0] d);
      @(posedge clk);
      a <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdat;
   endtask : r
   task automatic mc(input logic eg, input logic [3:0] t, input logic [4:0] exp);
      @(posedge clk);
      ev <= eg;
      iv <= ~eg;
      et <= t;
      it <= t;
      @(posedge clk);
      ev <= 1'b0;
      iv <= 1'b0;
      #1;
      chk("msg", {efw, ifw, ost, res, iins}, exp);
   endtask : mc
   task automatic pulses(input int b, input int s, input int n, output logic [15:0] c, output logic e);
      c = 0;
      e = 1'b0;
      repeat (4) @(posedge clk);
      for (int k = 0; k < 4 * n + 6; k++) begin
         @(posedge clk);
         gp[b] <= (k < 4 * n) && (k % 4 < 2);
         #1;
         if (cap[s] === 1'b1) begin
            c++;
            e = edg[s];
         end
      end
   endtask : pulses
   task automatic t_regs;
      logic [15:0] m [7] = '{16'h01FF, 16'hFFF7, 16'h0077, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFF00};
      logic [15:0] d;
      for (int i = 0; i < 8; i++) begin
         r(8'(8'h11 + i), d);
         chk("reset", d, 16'h0000);
      end
      w(8'h20, 16'hFFFF);
      for (int i = 0; i < 7; i++) begin
         w(8'(8'h11 + i), 16'hFFFF);
         r(8'(8'h11 + i), d);
         chk("mask", d, m[i]);
      end
      r(8'h20, d);
      chk("unmapped", d, 16'h0000);
      chk("levels", {clr, sw, so, ghold, gres}, 16'h1FFF);
      w(8'h17, 16'h6A00);
      chk("seconds fields", {sw, so}, 16'h006A);
      for (int i = 0; i < 7; i++) w(8'(8'h11 + i), 16'h0000);
   endtask : t_regs
   task automatic t_gen;
      w(8'h13, 16'h0004);
      chk("rst1", grst, 16'h0001);
      @(posedge clk);
      #1;
      chk("rst1 end", grst, 16'h0000);
      w(8'h13, 16'h0024);
      chk("rst2", {grst, ghold}, 16'h0002);
      w(8'h13, 16'h0051);
      chk("rst3", {grst, ghold, gres}, 16'h0023);
      w(8'h13, 16'h0000);
   endtask : t_gen
   task automatic t_stamp;
      logic [15:0] c;
      logic e;
      w(8'h12, 16'h0500);
      pulses(0, 1, 2, c, e);
      chk("stamp two", {c[14:0], e}, 16'h0005);
      w(8'h12, 16'hF000);
      pulses(2, 2, 1, c, e);
      chk("stamp three", {c[14:0], e}, 16'h0004);
      w(8'h12, 16'h0000);
      @(posedge clk);
      es <= 1'b1;
      is <= 1'b1;
      @(posedge clk);
      es <= 1'b0;
      is <= 1'b0;
      #1;
      chk("sop", {cap, edg}, 16'h0030);
   endtask : t_stamp
   task automatic t_div;
      int d1 [10] = '{0, 1, 3, 0, 0, 0, 0, 0, 0, 0};
      int d2 [10] = '{0, 0, 0, 4, 1, 5, 2, 6, 3, 7};
      int n [10] = '{3, 3, 6, 4, 20, 160, 1000, 800, 1000, 8000};
      int ex [10] = '{3, 3, 2, 2, 2, 2, 1, 1, 1, 1};
      logic [15:0] c;
      logic e;
      for (int i = 0; i < 10; i++) begin
         w(8'h14, 16'(d1[i]));
         w(8'h12, 16'(16'h0060 + d2[i]));
         pulses(1, 0, n[i], c, e);
         chk("stamp one", c, 16'(ex[i]));
      end
   endtask : t_div
   task automatic t_msg;
      w(8'h15, 16'h0101);
      mc(1'b1, 4'h0, 5'b10000);
      mc(1'b1, 4'h1, 5'b00000);
      mc(1'b1, 4'h8, 5'b00000);
      mc(1'b0, 4'h0, 5'b01000);
      w(8'h15, 16'h8080);
      mc(1'b1, 4'h7, 5'b10000);
      mc(1'b0, 4'h7, 5'b01000);
      w(8'h12, 16'h1100);
      mc(1'b1, 4'h7, 5'b00000);
      mc(1'b0, 4'h7, 5'b00000);
      w(8'h16, 16'h1101);
      mc(1'b1, 4'h0, 5'b00100);
      mc(1'b1, 4'h1, 5'b00010);
      mc(1'b1, 4'h2, 5'b00000);
      mc(1'b0, 4'h0, 5'b00001);
      mc(1'b0, 4'h1, 5'b00000);
      w(8'h16, 16'h9400);
      mc(1'b1, 4'h2, 5'b00100);
      mc(1'b1, 4'h3, 5'b00010);
      w(8'h16, 16'h8000);
      mc(1'b1, 4'h3, 5'b00000);
      w(8'h16, 16'h2000);
      @(posedge clk);
      cm <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("circuit on", cins, 16'h0001);
      w(8'h16, 16'h0000);
      @(posedge clk);
      #1;
      chk("circuit off", cins, 16'h0000);
      @(posedge clk);
      cm <= 1'b0;
      w(8'h16, 16'h2000);
      @(posedge clk);
      #1;
      chk("circuit no mode", cins, 16'h0000);
      w(8'h16, 16'h0000);
   endtask : t_msg
   task automatic t_clk;
      logic [15:0] v [6] = '{16'h0003, 16'h0103, 16'h0001, 16'h0101, 16'h0100, 16'h0000};
      int ex [6] = '{8, 4, 12, 0, 0, 0};
      logic [15:0] h;
      for (int i = 0; i < 6; i++) begin
         w(8'h11, v[i]);
         repeat (6) @(posedge clk);
         h = 0;
         repeat (12) begin
            @(posedge clk);
            #1;
            h = h + 16'(cko);
         end
         chk("clock out", h, 16'(ex[i]));
      end
   endtask : t_clk
   task automatic end_sim;
      if (fails == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_gen;
      t_stamp;
      t_div;
      t_msg;
      t_clk;
      end_sim;
   end
   initial begin
      #700000;
      fails++;
      end_sim;
   end
endmodule : pte_event_ctrl_test
`default_nettype wire
